// ==== bench/efr_feature_read_assertions.sv ====
// checker: port-level properties of the feature read block
`timescale 1ns/1ps
module efr_feature_read_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOutEn,
	input wire logic chipEnableBit,
	input wire logic pageLocked,
	input wire logic writeStart,
	input wire logic writeBusy,
	input wire logic standby,
	input wire logic [7:0] pageAddress
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	localparam int WC = efr_pkg::WRITE_CYCLE_CYCLES;
	int busyRun;
	// length of the running write cycle, judged when busy drops
	always_ff @(posedge clock) begin
		busyRun <= (rst || !writeBusy) ? 0 : busyRun + 1;
	end
	sequence busyBegin;
		writeStart && !writeBusy ##1 writeBusy;
	endsequence
	a_busy_begin: assert property (writeStart |=> writeBusy)
		else $error("busy not raised");
	a_busy_hold: assert property (busyBegin |=> writeBusy[*8])
		else $error("busy dropped early");
	a_busy_length: assert property ($fell(writeBusy) |-> busyRun inside {[WC - 1:WC + 1]})
		else $error("write cycle length wrong");
	a_busy_refuse: assert property (writeBusy |-> !$rose(sdaOutEn))
		else $error("answer while busy");
	a_drive_low: assert property (sdaOutEn |-> !sdaOut)
		else $error("drive not low");
	a_standby_quiet: assert property (standby && $past(standby) |-> !sdaOutEn)
		else $error("drive in standby");
	a_rise_scl_low: assert property ($rose(sdaOutEn) |-> !sclIn)
		else $error("drive began with clock high");
	a_page_quiet: assert property (standby && $past(standby) |-> $stable(pageAddress))
		else $error("counter moved in standby");
endmodule : efr_feature_read_chk

bind efr_feature_read efr_feature_read_chk u_chk (.clock, .rst, .sclIn, .sdaIn, .sdaOut,
	.sdaOutEn, .chipEnableBit, .pageLocked, .writeStart, .writeBusy, .standby, .pageAddress);

// ==== bench/efr_i2c_ctrl.sv ====
// partner: behavioural bus controller driving the clock and data lines
`timescale 1ns/1ps
module efr_i2c_ctrl (
	input wire logic sdaLine,
	output logic scl,
	output logic sdaDrv
);
	// ****************
	// bus controller
	// ****************
	localparam time QTR = 16; // quarter of the 64 ns bus clock
	// idle: clock stands high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// one slot; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sdaDrv = b;
		#QTR;
		scl = 1'b1;
		#QTR;
		r = sdaLine;
		#QTR;
		scl = 1'b0;
		#QTR;
	endtask : bit_io
	// extra low time lets the device release an acknowledge first
	task automatic start_cond();
		sdaDrv = 1'b1;
		#(2 * QTR);
		scl = 1'b1;
		#QTR;
		sdaDrv = 1'b0;
		#QTR;
		scl = 1'b0;
		#QTR;
	endtask : start_cond
	task automatic stop_cond();
		sdaDrv = 1'b0;
		#QTR;
		scl = 1'b1;
		#QTR;
		sdaDrv = 1'b1;
		#QTR;
	endtask : stop_cond
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r); // release for the answer slot
		ack = !r;
	endtask : wr_byte
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!more, r); // last byte unacknowledged
	endtask : rd_byte
endmodule : efr_i2c_ctrl

// ==== bench/tb.sv ====
// testbench: feature reads through a modelled bus controller
`timescale 1ns/1ps
module tb;
	logic clock, rst, chipEnableBit, pageLocked, writeStart, sdaOut, sdaOutEn;
	logic writeBusy, standby, sclIn, sdaDrv;
	logic [7:0] pageAddress;
	wire logic sdaIn;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	// open-drain line with pull-up
	assign sdaIn = sdaDrv && !sdaOutEn;
	efr_feature_read u_dut (.clock, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOutEn, .chipEnableBit,
		.pageLocked, .writeStart, .writeBusy, .standby, .pageAddress);
	efr_i2c_ctrl u_ctrl (.sdaLine(sdaIn), .scl(sclIn), .sdaDrv(sdaDrv));
	always #2 clock = ~clock;
	// watchdog: a hung sequence ends the run as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] sel(input logic ce, input logic sp, input logic rd);
		return {efr_pkg::DEV_TYPE_CODE, ce, sp, 1'b0, rd};
	endfunction : sel
	// delivered contents: array and page erased, registers cleared except the fixed type ID value
	function automatic logic [7:0] exp_byte(input logic [7:0] feat, input logic sp);
		if (!sp || feat == efr_pkg::FEAT_ID_PAGE) return efr_pkg::ERASED_BYTE;
		if (feat == efr_pkg::FEAT_TYPE_ID) return efr_pkg::TYPE_ID_VALUE;
		return feat == efr_pkg::FEAT_CHIP_CFG ? efr_pkg::CHIP_CFG_RESET : efr_pkg::WR_PROT_RESET;
	endfunction : exp_byte
	task automatic addr_phase(input logic sp, input logic [7:0] feat, input logic [7:0] offs);
		logic a;
		u_ctrl.start_cond();
		u_ctrl.wr_byte(sel(chipEnableBit, sp, 1'b0), a);
		chk(8'(a), 8'h01, "select");
		u_ctrl.wr_byte(feat, a);
		chk(8'(a), 8'h01, "feature");
		u_ctrl.wr_byte(offs, a);
		chk(8'(a), 8'h01, "offset");
	endtask : addr_phase
	task automatic read_feat(input logic sp, input logic [7:0] feat, input logic [7:0] offs,
		input int n);
		logic a;
		logic [7:0] d, pa0;
		addr_phase(sp, feat, offs);
		u_ctrl.start_cond(); // same upper select bits
		u_ctrl.wr_byte(sel(chipEnableBit, sp, 1'b1), a);
		chk(8'(a), 8'h01, "read select");
		pa0 = pageAddress;
		for (int i = 0; i < n; i++) begin
			u_ctrl.rd_byte(i < n - 1, d);
			chk(d, exp_byte(feat, sp), "data");
		end
		u_ctrl.stop_cond();
		repeat (4) @(posedge clock);
		#1;
		d = (sp && feat == efr_pkg::FEAT_ID_PAGE) ? n[7:0] : 8'h00;
		chk(pageAddress, pa0 + d, "counter");
		chk(8'(standby), 8'h01, "standby");
	endtask : read_feat
	initial begin
		logic a;
		int k;
		int lockPick;
		clock = 0;
		rst = 1;
		chipEnableBit = 0;
		pageLocked = 0;
		writeStart = 0;
		void'($urandom(6));
		// random phase, but both lock states are visited over the two rounds
		lockPick = $urandom_range(1);
		repeat (12) @(posedge clock);
		#1 rst = 0;
		repeat (3) @(posedge clock);
		#1;
		chk({5'h00, standby, writeBusy, sdaOutEn}, 8'h04, "reset");
		chk(pageAddress, 8'h00, "reset counter");
		for (int r = 0; r < 2; r++) begin
			chipEnableBit = r[0] ^ 1'($urandom_range(1));
			pageLocked = r[0] ^ lockPick[0];
			read_feat(1'b1, efr_pkg::FEAT_CHIP_CFG, 8'h00, 3);
			read_feat(1'b1, efr_pkg::FEAT_WR_PROT, 8'h00, 3);
			read_feat(1'b1, efr_pkg::FEAT_TYPE_ID, 8'h00, 2);
			read_feat(1'b0, 8'($urandom), 8'($urandom), 2);
			read_feat(1'b1, efr_pkg::FEAT_ID_PAGE, 8'hFE, 3);
			read_feat(1'b1, efr_pkg::FEAT_ID_PAGE, 8'($urandom), $urandom_range(1, 4));
			// lock probe, discarded by a start and a stop
			addr_phase(1'b1, efr_pkg::FEAT_LOCK, 8'($urandom));
			u_ctrl.wr_byte(8'($urandom), a);
			chk(8'(a), 8'(!pageLocked), "lock");
			u_ctrl.start_cond();
			u_ctrl.stop_cond();
			repeat (4) @(posedge clock);
			#1;
			chk(8'(standby), 8'h01, "lock standby");
			chk(8'(sdaOutEn), 8'h00, "lock released");
			u_ctrl.start_cond();
			u_ctrl.wr_byte(sel(!chipEnableBit, 1'b1, 1'b0), a);
			chk(8'(a), 8'h00, "foreign select");
			u_ctrl.stop_cond();
			// a write cycle refuses selects until it completes
			@(posedge clock);
			#1 writeStart = 1;
			@(posedge clock);
			#1 writeStart = 0;
			k = 0;
			a = 0;
			while (!a && k < 20) begin
				u_ctrl.start_cond();
				u_ctrl.wr_byte(sel(chipEnableBit, 1'b1, 1'b0), a);
				u_ctrl.stop_cond();
				k++;
			end
			chk(8'(k > 1 && a), 8'h01, "busy poll");
		end
		complete_run();
	end
endmodule : tb

// ==== common/efr_pkg.sv ====
// package: constants, types and feature decode for the feature read block
package efr_pkg;
	// ****************************************
	// select code and address decode
	// ****************************************
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA; // upper nibble of select code
	localparam int SEL_CE_BIT = 3; // chip-enable bit position b3
	localparam int SEL_SPACE_BIT = 2; // 1 selects feature space
	localparam logic [7:0] FEAT_ID_PAGE = 8'h00; // first address byte per feature
	localparam logic [7:0] FEAT_TYPE_ID = 8'h01;
	localparam logic [7:0] FEAT_CHIP_CFG = 8'h02;
	localparam logic [7:0] FEAT_WR_PROT = 8'h03;
	localparam logic [7:0] FEAT_LOCK = 8'h04;
	// ****************************************
	// reset and delivery values
	// ****************************************
	localparam logic [7:0] CHIP_CFG_RESET = 8'h00;
	localparam logic [7:0] WR_PROT_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] TYPE_ID_VALUE = 8'h5A; // arbitrary identification value
	localparam int PAGE_DEPTH = 256;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLOCK_MHZ = 250;
	localparam int WRITE_CYCLE_US = 4; // internal_write_cycle_time
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_US * CLOCK_MHZ;
	localparam int BIT_LAST = 7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	typedef enum logic [1:0] {EFR_FEAT_PAGE, EFR_FEAT_REG, EFR_FEAT_LOCK, EFR_FEAT_MAIN} efr_feat_type;

	// bus events after the synchroniser
	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sda;
	} efr_bus_type;
endpackage : efr_pkg

// ==== hdl/efr_bus_sync.sv ====
// synchroniser and condition detector for the two bus pins
`timescale 1ns/1ps
module efr_bus_sync (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output efr_pkg::efr_bus_type bus
);
	logic [1:0] sclMeta;
	logic [1:0] sdaMeta;
	logic sclLast;
	logic sdaLast;

	// two-flop synchronisers; only the second stage feeds the edge logic
	always_ff @(posedge clock) begin
		if (rst) begin
			sclMeta <= 2'h3;
			sdaMeta <= 2'h3;
			sclLast <= 1'b1;
			sdaLast <= 1'b1;
		end else begin
			sclMeta <= {sclMeta[0], sclIn};
			sdaMeta <= {sdaMeta[0], sdaIn};
			sclLast <= sclMeta[1];
			sdaLast <= sdaMeta[1];
		end
	end

	// start and stop are data edges while the clock stays high
	always_comb begin
		bus.sclRise = sclMeta[1] & ~sclLast;
		bus.sclFall = ~sclMeta[1] & sclLast;
		bus.start = sclMeta[1] & sclLast & sdaLast & ~sdaMeta[1];
		bus.stop = sclMeta[1] & sclLast & ~sdaLast & sdaMeta[1];
		bus.sda = sdaMeta[1];
	end
endmodule : efr_bus_sync

// ==== hdl/efr_feature_read.sv ====
// feature read slave: select decode, address phase, register and page output
`timescale 1ns/1ps
module efr_feature_read (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOutEn,
	input wire logic chipEnableBit,
	input wire logic pageLocked,
	input wire logic writeStart,
	output logic writeBusy,
	output logic standby,
	output logic [7:0] pageAddress
);
	efr_pkg::efr_bus_type bus;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SELECT, ST_ADDR, ST_LOCKDATA, ST_READ, ST_ACKIN, ST_WAITSTART
	} efr_state_type;

	efr_state_type state;
	logic [7:0] shiftIn;
	logic [3:0] bitCount;
	logic [7:0] shiftOut;
	logic [7:0] addrFirst;
	logic addrCount;
	logic readMode;
	logic ackPending;
	logic ackValue;
	efr_pkg::efr_feat_type feat;
	logic [7:0] chipCfg;
	logic [7:0] wrProt;
	logic [7:0] idPage [0:efr_pkg::PAGE_DEPTH-1];
	logic [10:0] busyCount;
	logic selMatch;
	logic [7:0] readByte;

	// ****************************************
	// pin conditioning
	// ****************************************
	efr_bus_sync sync (
		.clock(clock),
		.rst(rst),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.bus(bus)
	);

	// ****************************************
	// stored feature contents
	// ****************************************
	// delivery values; write paths lie outside this block
	always_ff @(posedge clock) begin
		if (rst) begin
			chipCfg <= efr_pkg::CHIP_CFG_RESET;
			wrProt <= efr_pkg::WR_PROT_RESET;
		end
	end

	// page array filled with the erased value, no reset needed for memory
	initial begin
		for (int i = 0; i < efr_pkg::PAGE_DEPTH; i++) begin
			idPage[i] = efr_pkg::ERASED_BYTE;
		end
	end

	// internal write cycle timer, started by the write path outside
	always_ff @(posedge clock) begin
		if (rst) begin
			busyCount <= 11'h000;
			writeBusy <= 1'b0;
		end else if (writeStart) begin
			busyCount <= 11'(efr_pkg::WRITE_CYCLE_CYCLES);
			writeBusy <= 1'b1;
		end else if (busyCount != 11'h000) begin
			busyCount <= busyCount - 11'h001;
			writeBusy <= (busyCount != 11'h001);
		end
	end

	// ****************************************
	// decode
	// ****************************************
	// select matches device type and chip-enable bit, refused while busy
	assign selMatch = (shiftIn[7:4] == efr_pkg::DEV_TYPE_CODE)
		&& (shiftIn[efr_pkg::SEL_CE_BIT] == chipEnableBit)
		&& !writeBusy;

	// byte to send for the selected feature; registers repeat every byte
	always_comb begin
		readByte = efr_pkg::ERASED_BYTE;
		unique case (feat)
			efr_pkg::EFR_FEAT_PAGE: readByte = idPage[pageAddress];
			efr_pkg::EFR_FEAT_REG: begin
				if (addrFirst == efr_pkg::FEAT_CHIP_CFG) begin
					readByte = chipCfg;
				end else if (addrFirst == efr_pkg::FEAT_WR_PROT) begin
					readByte = wrProt;
				end else begin
					readByte = efr_pkg::TYPE_ID_VALUE;
				end
			end
			efr_pkg::EFR_FEAT_LOCK: readByte = efr_pkg::ERASED_BYTE;
			efr_pkg::EFR_FEAT_MAIN: readByte = efr_pkg::ERASED_BYTE;
		endcase
	end

	// ****************************************
	// protocol engine
	// ****************************************
	// bits sampled on rising clock, output changes on falling clock
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_IDLE;
			shiftIn <= 8'h00;
			bitCount <= 4'h0;
			shiftOut <= 8'hFF;
			addrFirst <= 8'h00;
			addrCount <= 1'b0;
			readMode <= 1'b0;
			ackPending <= 1'b0;
			ackValue <= 1'b0;
			feat <= efr_pkg::EFR_FEAT_MAIN;
			pageAddress <= 8'h00;
			sdaOut <= 1'b1;
			sdaOutEn <= 1'b0;
			standby <= 1'b1;
		end else if (bus.start) begin
			// a start always restarts command decode
			state <= ST_SELECT;
			bitCount <= 4'h0;
			sdaOutEn <= 1'b0;
			sdaOut <= 1'b1;
			ackPending <= 1'b0;
			standby <= 1'b0;
		end else if (bus.stop) begin
			state <= ST_IDLE;
			sdaOutEn <= 1'b0;
			sdaOut <= 1'b1;
			ackPending <= 1'b0;
			standby <= 1'b1;
		end else if (bus.sclRise) begin
			unique case (state)
				ST_IDLE, ST_WAITSTART: begin
				end
				ST_SELECT, ST_ADDR, ST_LOCKDATA: begin
					if (bitCount < efr_pkg::ACK_SLOT) begin
						shiftIn <= {shiftIn[6:0], bus.sda};
						bitCount <= bitCount + 4'h1;
					end else begin
						// ack slot just clocked by the controller
						bitCount <= 4'h0;
						if (!ackValue) begin
							state <= ST_WAITSTART;
						end else if (state == ST_SELECT && readMode) begin
							state <= ST_READ;
							shiftOut <= readByte;
						end else if (state == ST_SELECT) begin
							state <= ST_ADDR;
							addrCount <= 1'b0;
						end else if (state == ST_ADDR && addrCount) begin
							state <= (feat == efr_pkg::EFR_FEAT_LOCK) ? ST_LOCKDATA : ST_WAITSTART;
						end else if (state == ST_ADDR) begin
							addrCount <= 1'b1;
						end else begin
							state <= ST_WAITSTART; // truncated, awaits start
						end
					end
				end
				ST_READ: begin
					if (bitCount == 4'(efr_pkg::BIT_LAST)) begin
						state <= ST_ACKIN;
					end
					bitCount <= bitCount + 4'h1;
				end
				ST_ACKIN: begin
					bitCount <= 4'h0;
					if (bus.sda) begin
						state <= ST_WAITSTART; // no ack: stop transfer
						standby <= 1'b1;
					end else begin
						state <= ST_READ;
						shiftOut <= readByte;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end else if (bus.sclFall) begin
			// drive ack, data, or release on the falling clock
			if ((state == ST_SELECT || state == ST_ADDR || state == ST_LOCKDATA)
				&& bitCount == efr_pkg::ACK_SLOT && !ackPending) begin
				ackPending <= 1'b1;
				if (state == ST_SELECT) begin
					readMode <= shiftIn[0];
					ackValue <= selMatch;
					if (!shiftIn[0]) begin
						feat <= shiftIn[efr_pkg::SEL_SPACE_BIT]
							? efr_pkg::EFR_FEAT_REG : efr_pkg::EFR_FEAT_MAIN;
					end
				end else if (state == ST_ADDR && !addrCount) begin
					addrFirst <= shiftIn;
					ackValue <= 1'b1;
					if (feat == efr_pkg::EFR_FEAT_REG) begin
						if (shiftIn == efr_pkg::FEAT_ID_PAGE) begin
							feat <= efr_pkg::EFR_FEAT_PAGE;
						end else if (shiftIn == efr_pkg::FEAT_LOCK) begin
							feat <= efr_pkg::EFR_FEAT_LOCK;
						end
					end
				end else if (state == ST_ADDR) begin
					ackValue <= 1'b1;
					if (feat == efr_pkg::EFR_FEAT_PAGE || feat == efr_pkg::EFR_FEAT_LOCK) begin
						pageAddress <= shiftIn;
					end
				end else begin
					ackValue <= !pageLocked;
				end
				sdaOut <= 1'b0;
				sdaOutEn <= (state == ST_SELECT) ? selMatch
					: (state == ST_LOCKDATA) ? !pageLocked : 1'b1;
			end else if (state == ST_READ && bitCount <= 4'(efr_pkg::BIT_LAST)) begin
				ackPending <= 1'b0;
				sdaOut <= shiftOut[7];
				sdaOutEn <= !shiftOut[7];
				shiftOut <= {shiftOut[6:0], 1'b1};
			end else begin
				ackPending <= 1'b0;
				sdaOut <= 1'b1;
				sdaOutEn <= 1'b0;
				// page counter steps once per byte sent, wrapping at FFh
				if (state == ST_ACKIN && feat == efr_pkg::EFR_FEAT_PAGE) begin
					pageAddress <= pageAddress + 8'h01;
				end
			end
		end
	end
endmodule : efr_feature_read
